// *** rtl/fcp_ctrl.sv ***
// Purpose: Command interpreter of a disk controller: command, execution and result phases
// Assumes: Drive-side logic on the same clock answers each sector request
// Notes: Register port with read data one cycle after the read strobe
// Functional notes
// - Step interval 1-16 ms, code F is 1
// - Four result status bytes, readable in result phase
// - Main status separate, at select line low
// - Scan stride one consecutive, two alternate sectors
// - Transfer stops after final sector number
// - Density select low FM, high MFM
// - Multi-side continues at side 1 sector 1
//
// Our own choices: the placing of the registers and the strobed register port.
`include "fcp_map.svh"
module fcp_ctrl import fcp_pkg::*; #(
	parameter int STEP_UNIT_CYCLES = `FCP_STEP_UNIT_NS / `FCP_CLK_NS
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic IRQ,
	input wire logic INDEX,
	output logic XFER_REQ,
	output logic XFER_WRITE,
	output logic XFER_MFM,
	output logic [1:0] DRIVE_SEL,
	output logic XFER_HEAD,
	output logic [7:0] XFER_CYL,
	output logic [7:0] XFER_SECTOR,
	input wire logic SECT_DONE,
	input wire logic SCAN_MISMATCH,
	output logic STEP_PULSE,
	output logic STEP_DIR,
	output logic [3:0] STEP_INTERVAL
);
	fcp_state_type state_reg;
	logic [7:0] p_reg [0:8];
	logic [3:0] cnt_reg;
	logic [3:0] len_reg;
	logic [3:0] step_reg;
	logic [1:0] drv_reg;
	logic head_reg;
	logic [7:0] sect_reg;
	logic [1:0] stride_reg;
	logic wait_idx_reg;
	logic mism_reg;
	logic invalid_reg;
	logic [2:0] res_wr_reg;
	logic [2:0] res_rd_reg;
	logic [7:0] target_reg;
	logic [7:0] pcn_reg [0:3];
	logic [4:0] step_cnt_reg;
	logic step_pulse_reg;
	logic step_dir_reg;
	logic [16:0] ms_cnt_reg;
	logic [1:0] int_reg;
	logic [1:0] mask_reg;
	logic [7:0] rdata_reg;
	logic rsel_reg;
	logic idx_s1_reg, idx_s2_reg, idx_s3_reg, idx_lvl_reg;
	fcp_res_if rif();

	fcp_result_mem u_mem (
		.clk(CLK),
		.rif(rif)
	);

	wire [4:0] op_w = p_reg[0][4:0];
	wire is_scan_w = (op_w == FCP_OP_SCAN);
	wire wr_data_w = WR && (ADDR == `FCP_ADDR_DATA);
	wire rd_data_w = RD && (ADDR == `FCP_ADDR_DATA);
	wire rd_int_w = RD && (ADDR == `FCP_ADDR_INT);
	wire wr_mask_w = WR && (ADDR == `FCP_ADDR_MASK);
	wire res_read_w = rd_data_w && (state_reg == FCP_RES);
	wire [3:0] len_first_w = fcp_cmd_len(WDATA[4:0]);
	wire ms_tick_w = (ms_cnt_reg == 17'(STEP_UNIT_CYCLES - 1));
	wire [4:0] interval_w = `FCP_STEP_BASE - {1'b0, step_reg};
	wire step_due_w = ms_tick_w && (step_cnt_reg == interval_w - 5'h01);
	wire at_target_w = (pcn_reg[drv_reg] == target_reg);
	wire idx_rise_w = (idx_s2_reg == idx_s3_reg) && idx_s3_reg && !idx_lvl_reg;
	wire last_sect_w = (sect_reg >= p_reg[6]);
	wire xfer_ack_w = (state_reg == FCP_EXEC) && !wait_idx_reg && SECT_DONE;
	wire mism_w = mism_reg || (is_scan_w && SCAN_MISMATCH);
	wire res_done_w = (state_reg == FCP_WRES) && (res_wr_reg == `FCP_RES_LAST);
	wire seek_done_w = (state_reg == FCP_SEEK) && step_due_w && at_target_w;
	wire [1:0] int_set_w = {seek_done_w, res_done_w};
	wire [7:0] msr_w;
	logic [7:0] res_byte_w;

	// Main status kept apart from the result bytes
	assign msr_w = {(state_reg == FCP_IDLE) || (state_reg == FCP_CMD) || (state_reg == FCP_RES),
		state_reg == FCP_RES, (state_reg == FCP_EXEC) || (state_reg == FCP_SEEK),
		state_reg != FCP_IDLE, 4'h0};

	always_comb begin
		case (res_wr_reg)
			3'h0: res_byte_w = invalid_reg ? `FCP_RS0_INVALID : {5'h00, head_reg, drv_reg};
			3'h1: res_byte_w = 8'h00;
			3'h2: res_byte_w = {4'h0, is_scan_w && !mism_reg, is_scan_w && mism_reg, 2'h0};
			3'h3: res_byte_w = {5'h00, head_reg, drv_reg};
			3'h4: res_byte_w = p_reg[2];
			3'h5: res_byte_w = {7'h00, head_reg};
			3'h6: res_byte_w = sect_reg;
			default: res_byte_w = p_reg[5];
		endcase
	end

	assign rif.wr_en = (state_reg == FCP_WRES);
	assign rif.wr_addr = res_wr_reg;
	assign rif.wr_data = res_byte_w;
	assign rif.rd_addr = res_rd_reg;

	assign RDATA = rsel_reg ? rif.rd_data : rdata_reg;
	assign IRQ = |(int_reg & mask_reg);
	assign XFER_REQ = (state_reg == FCP_EXEC) && !wait_idx_reg;
	assign XFER_WRITE = (op_w == FCP_OP_WRITE);
	assign XFER_MFM = p_reg[0][6];
	assign DRIVE_SEL = drv_reg;
	assign XFER_HEAD = head_reg;
	assign XFER_CYL = p_reg[2];
	assign XFER_SECTOR = sect_reg;
	assign STEP_PULSE = step_pulse_reg;
	assign STEP_DIR = step_dir_reg;
	assign STEP_INTERVAL = step_reg;

	// Index pin synchroniser, change taken once stages two and three agree
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			idx_s1_reg <= 1'b0;
			idx_s2_reg <= 1'b0;
			idx_s3_reg <= 1'b0;
			idx_lvl_reg <= 1'b0;
		end else begin
			idx_s1_reg <= INDEX;
			idx_s2_reg <= idx_s1_reg;
			idx_s3_reg <= idx_s2_reg;
			if (idx_s2_reg == idx_s3_reg) begin
				idx_lvl_reg <= idx_s3_reg;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ms_cnt_reg <= 17'h00000;
		end else begin
			ms_cnt_reg <= ms_tick_w ? 17'h00000 : ms_cnt_reg + 17'h00001;
		end
	end

	// Register port; status set wins over clear on read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			int_reg <= 2'h0;
			mask_reg <= `FCP_MASK_RST;
			rdata_reg <= 8'h00;
			rsel_reg <= 1'b0;
		end else begin
			int_reg <= (int_reg & ~{2{rd_int_w}}) | int_set_w;
			if (wr_mask_w) begin
				mask_reg <= WDATA[1:0];
			end
			rsel_reg <= res_read_w;
			if (RD && ADDR == `FCP_ADDR_MSR) begin
				rdata_reg <= msr_w;
			end else if (rd_int_w) begin
				rdata_reg <= {6'h00, int_reg};
			end else if (RD && ADDR == `FCP_ADDR_MASK) begin
				rdata_reg <= {6'h00, mask_reg};
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= FCP_IDLE;
			for (int i = 0; i < 9; i++) begin
				p_reg[i] <= 8'h00;
			end
			for (int j = 0; j < 4; j++) begin
				pcn_reg[j] <= 8'h00;
			end
			cnt_reg <= 4'h0;
			len_reg <= 4'h0;
			step_reg <= `FCP_STEP_RST;
			drv_reg <= 2'h0;
			head_reg <= 1'b0;
			sect_reg <= 8'h00;
			stride_reg <= 2'h1;
			wait_idx_reg <= 1'b0;
			mism_reg <= 1'b0;
			invalid_reg <= 1'b0;
			res_wr_reg <= 3'h0;
			res_rd_reg <= 3'h0;
			target_reg <= 8'h00;
			step_cnt_reg <= 5'h00;
			step_pulse_reg <= 1'b0;
			step_dir_reg <= 1'b0;
		end else begin
			step_pulse_reg <= 1'b0;
			case (state_reg)
				FCP_IDLE: begin
					if (wr_data_w) begin
						p_reg[0] <= WDATA;
						cnt_reg <= 4'h1;
						len_reg <= len_first_w;
						state_reg <= (len_first_w == 4'h1) ? FCP_DISP : FCP_CMD;
					end
				end
				FCP_CMD: begin
					if (wr_data_w) begin
						p_reg[cnt_reg] <= WDATA;
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg + 4'h1 == len_reg) begin
							state_reg <= FCP_DISP;
						end
					end
				end
				FCP_DISP: begin
					drv_reg <= p_reg[1][1:0];
					head_reg <= p_reg[1][2];
					mism_reg <= 1'b0;
					invalid_reg <= 1'b0;
					res_wr_reg <= 3'h0;
					step_cnt_reg <= 5'h00;
					stride_reg <= (is_scan_w && p_reg[8] == 8'h02) ? 2'h2 : 2'h1;
					case (op_w)
						FCP_OP_SPECIFY: begin
							step_reg <= p_reg[1][7:4];
							state_reg <= FCP_IDLE;
						end
						FCP_OP_SEEK: begin
							target_reg <= p_reg[2];
							state_reg <= FCP_SEEK;
						end
						FCP_OP_READ, FCP_OP_WRITE, FCP_OP_SCAN: begin
							sect_reg <= p_reg[4];
							wait_idx_reg <= 1'b0;
							state_reg <= FCP_EXEC;
						end
						FCP_OP_READ_TRACK: begin
							sect_reg <= 8'h01;
							wait_idx_reg <= 1'b1;
							state_reg <= FCP_EXEC;
						end
						default: begin
							invalid_reg <= 1'b1;
							state_reg <= FCP_WRES;
						end
					endcase
				end
				FCP_EXEC: begin
					if (wait_idx_reg && idx_rise_w) begin
						wait_idx_reg <= 1'b0;
					end
					if (xfer_ack_w) begin
						mism_reg <= mism_w;
						if (last_sect_w) begin
							if (p_reg[0][7] && !head_reg) begin
								head_reg <= 1'b1;
								sect_reg <= 8'h01;
							end else begin
								state_reg <= FCP_WRES;
							end
						end else begin
							sect_reg <= sect_reg + {6'h00, stride_reg};
						end
					end
				end
				FCP_WRES: begin
					res_wr_reg <= res_wr_reg + 3'h1;
					if (res_done_w) begin
						res_rd_reg <= 3'h0;
						state_reg <= FCP_RES;
					end
				end
				FCP_RES: begin
					if (res_read_w) begin
						res_rd_reg <= res_rd_reg + 3'h1;
						if (res_rd_reg == `FCP_RES_LAST) begin
							state_reg <= FCP_IDLE;
						end
					end
				end
				FCP_SEEK: begin
					if (ms_tick_w) begin
						step_cnt_reg <= step_due_w ? 5'h00 : step_cnt_reg + 5'h01;
					end
					if (step_due_w) begin
						if (at_target_w) begin
							state_reg <= FCP_IDLE;
						end else begin
							step_pulse_reg <= 1'b1;
							step_dir_reg <= (target_reg > pcn_reg[drv_reg]);
							pcn_reg[drv_reg] <= (target_reg > pcn_reg[drv_reg]) ?
								pcn_reg[drv_reg] + 8'h01 : pcn_reg[drv_reg] - 8'h01;
						end
					end
				end
				default: state_reg <= FCP_IDLE;
			endcase
		end
	end
endmodule

// *** rtl/fcp_map.svh ***
// Purpose: Offsets, bit positions, reset values and timing counts of the command interpreter
// Assumes: 100 MHz clock
// Notes: Included by the controller only
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

`define FCP_ADDR_MSR 2'h0
`define FCP_ADDR_DATA 2'h1
`define FCP_ADDR_INT 2'h2
`define FCP_ADDR_MASK 2'h3

`define FCP_MSR_RQM 7
`define FCP_MSR_DIO 6
`define FCP_MSR_EXEC 5
`define FCP_MSR_BUSY 4

`define FCP_INT_RES 0
`define FCP_INT_SEEK 1

`define FCP_STEP_RST 4'h0
`define FCP_MASK_RST 2'h0
`define FCP_STEP_BASE 5'h10

`define FCP_CLK_NS 10
`define FCP_STEP_UNIT_NS 1000000

`define FCP_RES_LAST 3'h7
`define FCP_RS0_INVALID 8'h80

`endif

// *** rtl/fcp_pkg.sv ***
// Purpose: Types shared by the command interpreter files
// Assumes: Nothing
// Notes: Opcodes sit in the low five bits of the first command byte
package fcp_pkg;

	typedef enum logic [2:0] {
		FCP_IDLE = 3'h0,
		FCP_CMD = 3'h1,
		FCP_DISP = 3'h3,
		FCP_EXEC = 3'h2,
		FCP_WRES = 3'h6,
		FCP_RES = 3'h7,
		FCP_SEEK = 3'h5
	} fcp_state_type;

	typedef enum logic [4:0] {
		FCP_OP_READ_TRACK = 5'h02,
		FCP_OP_SPECIFY = 5'h03,
		FCP_OP_WRITE = 5'h05,
		FCP_OP_READ = 5'h06,
		FCP_OP_SEEK = 5'h0F,
		FCP_OP_SCAN = 5'h11
	} fcp_op_type;

	function automatic logic [3:0] fcp_cmd_len(input logic [4:0] op);
		case (op)
			FCP_OP_SPECIFY: fcp_cmd_len = 4'h2;
			FCP_OP_SEEK: fcp_cmd_len = 4'h3;
			FCP_OP_READ, FCP_OP_WRITE, FCP_OP_READ_TRACK: fcp_cmd_len = 4'h8;
			FCP_OP_SCAN: fcp_cmd_len = 4'h9;
			default: fcp_cmd_len = 4'h1;
		endcase
	endfunction

endpackage

// *** rtl/fcp_res_if.sv ***
// Purpose: Write and read port of the result byte store
// Assumes: Same clock on both ends
// Notes: Read data appear one cycle after the address
interface fcp_res_if;
	logic wr_en;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;
	logic [2:0] rd_addr;
	logic [7:0] rd_data;

	modport ctrl(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** rtl/fcp_result_mem.sv ***
// Purpose: Eight-byte store for result status and sector id bytes
// Assumes: Single clock
// Notes: Registered read, no reset on contents
module fcp_result_mem (
	input wire logic clk,
	fcp_res_if.mem rif
);
	logic [7:0] mem_q [0:7];

	always_ff @(posedge clk) begin
		if (rif.wr_en) begin
			mem_q[rif.wr_addr] <= rif.wr_data;
		end
		rif.rd_data <= mem_q[rif.rd_addr];
	end
endmodule

// *** verif/fcp_ctrl_chk.sv ***
// Purpose: Port checks of the command interpreter
// Assumes: One clock
// Notes: Last nine data bytes give the command fields
module fcp_ctrl_chk #(
	parameter int STEP_UNIT_CYCLES = 10
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic INDEX,
	input wire logic XFER_REQ,
	input wire logic XFER_MFM,
	input wire logic XFER_HEAD,
	input wire logic [7:0] XFER_SECTOR,
	input wire logic SECT_DONE,
	input wire logic STEP_PULSE,
	input wire logic [3:0] STEP_INTERVAL
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [71:0] w_reg;
	int gap_reg;
	logic gap_ok_reg;
	int idx_reg;
	wire logic [7:0] fin = w_reg[15:8];
	// Nine-byte scan shifts the eight-byte fields one place up
	wire logic scan = w_reg[68:64] == 5'h11;
	wire logic rw = !scan && (w_reg[60:56] == 5'h06 || w_reg[60:56] == 5'h05);
	wire logic go = SECT_DONE && XFER_REQ;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			w_reg <= 72'h0;
			gap_reg <= 0;
			gap_ok_reg <= 1'b0;
			idx_reg <= 0;
		end else begin
			if (WR && ADDR == 2'h1)
				w_reg <= {w_reg[63:0], WDATA};
			gap_reg <= STEP_PULSE ? 0 : gap_reg + 1;
			gap_ok_reg <= STEP_PULSE || (gap_ok_reg && !WR);
			idx_reg <= $rose(INDEX) ? 0 : idx_reg + 1;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence last_sect;
		go && rw && XFER_SECTOR == fin;
	endsequence
	sequence side_wrap;
		go && rw && w_reg[63] && !XFER_HEAD && XFER_SECTOR >= fin;
	endsequence
	step_gap_a: assert property (STEP_PULSE && gap_ok_reg
		|-> gap_reg == (16 - STEP_INTERVAL) * STEP_UNIT_CYCLES - 1) else $error("step gap");
	data_quiet_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("data not quiet");
	exec_status_a: assert property (RD && ADDR == 2'h0 && XFER_REQ |=> RDATA[7:4] == 4'h3)
		else $error("main status");
	scan_stride_a: assert property (go && scan && XFER_SECTOR < w_reg[23:16]
		|=> XFER_SECTOR == $past(XFER_SECTOR) + (w_reg[7:0] == 8'h02 ? 8'h02 : 8'h01)) else $error("stride");
	track_start_a: assert property ($rose(XFER_REQ) && !scan && w_reg[60:56] == 5'h02
		|-> XFER_SECTOR == 8'h01 && idx_reg inside {[1:8]}) else $error("track start");
	final_stop_a: assert property (last_sect ##0 !(w_reg[63] && !XFER_HEAD) |=> !XFER_REQ)
		else $error("no stop");
	density_mode_a: assert property (XFER_REQ && rw |-> XFER_MFM == w_reg[62])
		else $error("density");
	side_wrap_a: assert property (side_wrap |=> XFER_HEAD && XFER_SECTOR == 8'h01)
		else $error("side wrap");
endmodule

bind fcp_ctrl fcp_ctrl_chk #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) chk (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.INDEX, .XFER_REQ, .XFER_MFM, .XFER_HEAD, .XFER_SECTOR, .SECT_DONE, .STEP_PULSE, .STEP_INTERVAL);

// *** verif/fcp_drive_model.sv ***
// Purpose: Drive-side stand-in answering sector requests
// Assumes: Same clock as the controller
// Notes: Index pulse free running, one per 64 cycles
module fcp_drive_model (
	input wire logic CLK,
	input wire logic RST,
	input wire logic XFER_REQ,
	input wire logic SLOW,
	input wire logic MISMATCH,
	output logic INDEX,
	output logic SECT_DONE,
	output logic SCAN_MISMATCH
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg;
	logic [5:0] rot_reg;
	wire logic ready = wait_reg == (SLOW ? 4'h9 : 4'h2);
	assign INDEX = rot_reg < 6'h04;
	// Wrong level outside the done cycle
	assign SCAN_MISMATCH = SECT_DONE ? MISMATCH : !MISMATCH;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wait_reg <= 4'h0;
			rot_reg <= 6'h00;
			SECT_DONE <= 1'b0;
		end else begin
			rot_reg <= rot_reg + 6'h01;
			SECT_DONE <= XFER_REQ && ready;
			wait_reg <= (XFER_REQ && !ready) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// *** verif/fcp_ctrl_tb.sv ***
// Purpose: Self-checking bench of the command interpreter
// Assumes: Step unit shortened to 10 cycles
// Notes: Table rows run transfer commands, seeks follow
module fcp_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] op, b1, r, fin, scan_stride;
		logic mis, eh;
		logic [7:0] er, rs2;
	} fcp_row_type;
	fcp_row_type rows [6] = '{
		'{8'h46, 8'h01, 8'h03, 8'h05, 8'h00, 1'b0, 1'b0, 8'h05, 8'h00},
		'{8'h05, 8'h06, 8'h01, 8'h02, 8'h00, 1'b0, 1'b1, 8'h02, 8'h00},
		'{8'hC6, 8'h03, 8'h04, 8'h05, 8'h00, 1'b0, 1'b1, 8'h05, 8'h00},
		'{8'h11, 8'h00, 8'h01, 8'h03, 8'h01, 1'b0, 1'b0, 8'h03, 8'h08},
		'{8'h51, 8'h02, 8'h01, 8'h05, 8'h02, 1'b1, 1'b0, 8'h05, 8'h04},
		'{8'h02, 8'h01, 8'h09, 8'h03, 8'h00, 1'b0, 1'b0, 8'h03, 8'h00}};
	logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, slow = 1'b0, mis = 1'b0;
	logic [1:0] ADDR = 2'h0;
	logic [7:0] WDATA = 8'h00, h;
	logic [7:0] cmd [9];
	logic [7:0] res [8];
	logic [7:0] RDATA, XFER_CYL, XFER_SECTOR;
	logic [3:0] STEP_INTERVAL;
	logic [1:0] DRIVE_SEL;
	logic IRQ, INDEX, XFER_REQ, XFER_WRITE, XFER_MFM, XFER_HEAD, SECT_DONE, SCAN_MISMATCH, STEP_PULSE, STEP_DIR;
	int bad_count = 0, tests_run = 0, cyc = 0, pulses = 0;
	fcp_ctrl #(.STEP_UNIT_CYCLES(10)) dut (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .INDEX, .XFER_REQ,
		.XFER_WRITE, .XFER_MFM, .DRIVE_SEL, .XFER_HEAD, .XFER_CYL, .XFER_SECTOR, .SECT_DONE, .SCAN_MISMATCH,
		.STEP_PULSE, .STEP_DIR, .STEP_INTERVAL);
	fcp_drive_model drv (.CLK, .RST, .XFER_REQ, .SLOW(slow), .MISMATCH(mis), .INDEX, .SECT_DONE, .SCAN_MISMATCH);
	initial begin
		forever #5 CLK = ~CLK;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk(n, e & m, RDATA & m);
		@(posedge CLK);
	endtask
	always @(posedge CLK) begin
		if (STEP_PULSE === 1'b1)
			pulses = pulses + (STEP_DIR === 1'b1 ? 1 : 100);
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		chk("step code", 8'h00, {4'h0, STEP_INTERVAL});
		rd(2'h0, 8'h80, 8'hF0, "idle status");
		rd(2'h1, 8'h00, 8'hFF, "idle data");
		wr(2'h2, 8'h03);
		rd(2'h2, 8'h00, 8'hFF, "int status");
		wr(2'h3, 8'h01);
		foreach (rows[i]) begin
			slow <= i[0];
			mis <= rows[i].mis;
			cmd = '{rows[i].op, rows[i].b1, 8'h07, {7'h00, rows[i].b1[2]}, rows[i].r, 8'h02, rows[i].fin, 8'h1B,
				rows[i].scan_stride};
			for (int j = 0; j < (rows[i].op[4:0] == 5'h11 ? 9 : 8); j++)
				wr(2'h1, cmd[j]);
			do @(posedge CLK); while (XFER_REQ !== 1'b1);
			chk("drive", {4'h0, rows[i].op == 8'h05, rows[i].op[6], rows[i].b1[1:0]},
				{4'h0, XFER_WRITE, XFER_MFM, DRIVE_SEL});
			chk("cylinder", 8'h07, XFER_CYL);
			rd(2'h0, 8'h30, 8'hF0, "exec status");
			do @(posedge CLK); while (IRQ !== 1'b1);
			rd(2'h0, 8'hD0, 8'hF0, "result status");
			rd(2'h2, 8'h01, 8'hFF, "int status");
			h = {5'h00, rows[i].eh, rows[i].b1[1:0]};
			res = '{h, 8'h00, rows[i].rs2, h, 8'h07, {7'h00, rows[i].eh}, rows[i].er, 8'h02};
			for (int j = 0; j < 8; j++)
				rd(2'h1, res[j], 8'hFF, "result");
			rd(2'h1, 8'h00, 8'hFF, "after result");
		end
		// Unknown opcode gives the invalid first status byte
		wr(2'h1, 8'h1F);
		do @(posedge CLK); while (IRQ !== 1'b1);
		rd(2'h2, 8'h01, 8'hFF, "invalid int");
		for (int j = 0; j < 8; j++)
			rd(2'h1, j == 0 ? 8'h80 : 8'h00, j < 3 ? 8'hFF : 8'h00, "invalid result");
		rd(2'h0, 8'h80, 8'hF0, "idle again");
		for (int k = 0; k < 2; k++) begin
			wr(2'h1, 8'h03);
			wr(2'h1, {4'hE + k[3:0], 4'h0});
			@(posedge CLK);
			chk("step code", {4'h0, 4'hE + k[3:0]}, {4'h0, STEP_INTERVAL});
			pulses = 0;
			wr(2'h1, 8'h0F);
			wr(2'h1, 8'h00);
			wr(2'h1, 8'h03 + {k[6:0], 1'b0});
			repeat (120) @(posedge CLK);
			chk("step count", 8'h03 - k[7:0], pulses[7:0]);
			chk("masked irq", 8'h00, {7'h00, IRQ});
			rd(2'h2, 8'h02, 8'hFF, "seek done");
			rd(2'h2, 8'h00, 8'hFF, "cleared");
		end
		// Reset in the middle of a command
		wr(2'h1, 8'h46);
		rd(2'h0, 8'h90, 8'hF0, "command status");
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		chk("step code", 8'h00, {4'h0, STEP_INTERVAL});
		chk("reset irq", 8'h00, {7'h00, IRQ});
		rd(2'h0, 8'h80, 8'hF0, "reset status");
		stop_test();
	end
endmodule
